/* verilog/isu_top.sv */
`timescale 1ns/1ps
`include "isu_defs.svh"

module isu_top
   import isu_pkg::*;
#(
   parameter int PULSE_CYC  = `ISU_PULSE_CYC,
   parameter int GAP_CYC    = `ISU_GAP_CYC,
   parameter int PERIOD_CYC = `ISU_PERIOD_CYC,
   localparam int PCW       = $clog2(PERIOD_CYC + 1)
)
(
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire isu_mode_t              device_mode,
   input  wire isu_status_t            status,
   input  wire isu_wake_t              wake_status_reg,
   input  wire logic [`ISU_ADDR_W-1:0] reg_addr,
   input  wire logic [`ISU_DATA_W-1:0] reg_wr_data,
   input  wire logic                   reg_wr_en,
   input  wire logic                   reg_rd_en,
   output logic      [`ISU_DATA_W-1:0] reg_rd_data,
   output logic                        irq_out_n,
   output logic                        irq
);

   localparam int WQ_N = $bits(isu_wake_t);

   logic [`ISU_GRP_N-1:0]      grp_mask_reg;
   logic [`ISU_WAKE_CFG_N-1:0] wake_cfg_reg;
   logic [`ISU_CTRL_N-1:0]     ctrl_reg;
   logic [`ISU_EVT_N-1:0]      evt_stat_reg;
   logic [`ISU_EVT_N-1:0]      evt_mask_reg;
   logic [`ISU_GRP_N-1:0]      grp_prev_reg;
   logic [WQ_N-1:0]            wake_prev_reg;
   logic [PCW-1:0]             per_cnt_reg;
   logic                       pend_reg;

   logic                       mode_active;
   logic [`ISU_GRP_N-1:0]      grp_flags;
   logic [`ISU_GRP_N-1:0]      grp_en;
   logic [`ISU_GRP_N-1:0]      grp_edge;
   logic [WQ_N-1:0]            wake_cfg_vec;
   logic [WQ_N-1:0]            wake_q;
   logic [WQ_N-1:0]            wake_edge;
   logic                       edge_any;
   logic                       exc;
   logic                       pending;
   logic                       per_run;
   logic                       per_hit;
   logic                       new_req;
   logic                       pg_req;
   logic                       pg_start;
   logic                       pg_low;
   logic                       merged;
   logic [`ISU_EVT_N-1:0]      evt_set;
   logic [`ISU_EVT_N-1:0]      evt_clr;

   function automatic logic or_except(input logic [7:0] v, input logic [7:0] excl);
      return |(v & ~excl);
   endfunction

   function automatic logic hit(input logic [`ISU_ADDR_W-1:0] ofs);
      return reg_addr == ofs;
   endfunction

   // mode is only read here, nothing of this block feeds back into mode control
   assign mode_active = (device_mode == ISU_MODE_NORMAL) || (device_mode == ISU_MODE_STOP);

   always_comb
   begin
      grp_flags = '0;
      grp_flags[`ISU_GRP_SUPPLY]  = or_except(status.supply_status,
                                              (8'h01 << `ISU_SUP_POR) | (8'h01 << `ISU_SUP_UV) |
                                              (8'h01 << `ISU_SUP_SC)  | (8'h01 << `ISU_SUP_OV));
      grp_flags[`ISU_GRP_TEMP]    = or_except(status.thermal_status_reg, 8'h01 << `ISU_TH_THERMAL_SHUTDOWN_LEVEL2);
      grp_flags[`ISU_GRP_BUS]     = |status.bus_status;
      grp_flags[`ISU_GRP_HS]      = |status.highside_fault_status_reg;
      grp_flags[`ISU_GRP_BRIDGE]  = |status.drain_source_overvoltage_reg;
      grp_flags[`ISU_GRP_SPI_CRC] = status.spi_fail | status.crc_fail;
   end

   assign grp_en = grp_flags & grp_mask_reg;

   // brake events qualify as wake sources only while brake handling is on
   assign wake_cfg_vec = {{4{ctrl_reg[`ISU_CTRL_BRAKE]}}, wake_cfg_reg};
   assign wake_q       = wake_status_reg & wake_cfg_vec;

   // exceptions stay out of every group so they can only reach the pin periodically
   assign exc = status.supply_status[`ISU_SUP_UV] | status.supply_status[`ISU_SUP_SC] |
                status.supply_status[`ISU_SUP_OV] | status.thermal_status_reg[`ISU_TH_THERMAL_SHUTDOWN_LEVEL2];

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         grp_prev_reg  <= '0;
         wake_prev_reg <= '0;
      end
      else
      begin
         grp_prev_reg  <= grp_en;
         wake_prev_reg <= wake_q;
      end
   end

   assign grp_edge  = grp_en & ~grp_prev_reg;
   assign wake_edge = wake_q & ~wake_prev_reg;
   assign edge_any  = (|grp_edge) | (|wake_edge);

   // status is level: it stays set until host clears it, which keeps the repeat alive
   assign pending = (|grp_en) | (|wake_q) | exc;
   assign per_run = mode_active && ctrl_reg[`ISU_CTRL_PERIODIC] && pending;
   assign per_hit = per_run && (per_cnt_reg == PCW'(PERIOD_CYC - 1));

   always_ff @(posedge clk)
   begin
      if (rst || !per_run || pg_start || per_hit)
         per_cnt_reg <= '0;
      else
         per_cnt_reg <= per_cnt_reg + PCW'(1);
   end

   assign new_req = mode_active && (edge_any || per_hit);
   assign merged  = new_req && pg_low;
   assign pg_req  = mode_active && (pend_reg || (new_req && !pg_low));

   // a request made in the gap waits here until the gap has run out
   always_ff @(posedge clk)
   begin
      if (rst || !mode_active || pg_start)
         pend_reg <= 1'b0;
      else if (new_req && !pg_low)
         pend_reg <= 1'b1;
   end

   isu_pulse_gen #(
      .WIDTH_CYC (PULSE_CYC),
      .GAP_CYC   (GAP_CYC)
   ) u_pulse (
      .clk       (clk),
      .rst       (rst),
      .active    (mode_active),
      .req       (pg_req),
      .start     (pg_start),
      .low       (pg_low),
      .irq_out_n (irq_out_n)
   );

   always_ff @(posedge clk)
   begin
      if (rst)
         grp_mask_reg <= `ISU_RST_GRP_MASK;
      else if (reg_wr_en && hit(`ISU_OFS_GRP_MASK))
         grp_mask_reg <= reg_wr_data[`ISU_GRP_N-1:0];
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         wake_cfg_reg <= `ISU_RST_WAKE_CFG;
      else if (reg_wr_en && hit(`ISU_OFS_WAKE_CFG))
         wake_cfg_reg <= reg_wr_data[`ISU_WAKE_CFG_N-1:0];
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         ctrl_reg <= `ISU_RST_CTRL;
      else if (reg_wr_en && hit(`ISU_OFS_CTRL))
         ctrl_reg <= reg_wr_data[`ISU_CTRL_N-1:0];
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         evt_mask_reg <= `ISU_RST_EVT_MASK;
      else if (reg_wr_en && hit(`ISU_OFS_EVT_MASK))
         evt_mask_reg <= reg_wr_data[`ISU_EVT_N-1:0];
   end

   always_comb
   begin
      evt_set = '0;
      evt_set[`ISU_EVT_PULSE]    = pg_start;
      evt_set[`ISU_EVT_PERIODIC] = per_hit;
      evt_set[`ISU_EVT_MERGED]   = merged;
      evt_clr = (reg_wr_en && hit(`ISU_OFS_EVT_STAT)) ? reg_wr_data[`ISU_EVT_N-1:0] : '0;
   end

   // set beats a simultaneous write-one-to-clear
   always_ff @(posedge clk)
   begin
      if (rst)
         evt_stat_reg <= '0;
      else
         evt_stat_reg <= (evt_stat_reg & ~evt_clr) | evt_set;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         irq <= 1'b0;
      else
         irq <= |(evt_stat_reg & evt_mask_reg);
   end

   always_ff @(posedge clk)
   begin
      if (rst || !reg_rd_en)
         reg_rd_data <= '0;
      else
      begin
         reg_rd_data <= '0;
         if (hit(`ISU_OFS_GRP_MASK))
            reg_rd_data[`ISU_GRP_N-1:0] <= grp_mask_reg;
         else if (hit(`ISU_OFS_WAKE_CFG))
            reg_rd_data[`ISU_WAKE_CFG_N-1:0] <= wake_cfg_reg;
         else if (hit(`ISU_OFS_CTRL))
            reg_rd_data[`ISU_CTRL_N-1:0] <= ctrl_reg;
         else if (hit(`ISU_OFS_EVT_STAT))
            reg_rd_data[`ISU_EVT_N-1:0] <= evt_stat_reg;
         else if (hit(`ISU_OFS_EVT_MASK))
            reg_rd_data[`ISU_EVT_N-1:0] <= evt_mask_reg;
         else if (hit(`ISU_OFS_FLAGS))
         begin
            reg_rd_data[`ISU_GRP_N-1:0]    <= grp_flags;
            reg_rd_data[`ISU_FLG_EXC]      <= exc;
            reg_rd_data[`ISU_FLG_PENDING]  <= pending;
            reg_rd_data[`ISU_FLG_LOW]      <= pg_low;
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   AST_NO_REQ_OFF: assert property (!mode_active |-> !pg_req && !pg_start)
      else $error("pulse requested outside active modes");
   AST_PER_BOUND: assert property (per_cnt_reg < PERIOD_CYC)
      else $error("repeat counter past its period");
   AST_PER_FIRE: assert property (per_hit && !pg_low |-> pg_req)
      else $error("repeat period elapsed without request");
   // the counter is cleared one edge after the enable drops, so its zero is checked a cycle later
   AST_PER_OFF: assert property (!ctrl_reg[`ISU_CTRL_PERIODIC] |-> !per_hit ##1 per_cnt_reg == '0)
      else $error("repetition active while disabled");
   AST_EDGE_REQ: assert property ((mode_active && edge_any && !pg_low) |-> pg_req)
      else $error("event edge gave no request");
   AST_WAKE_QUAL: assert property ((wake_edge & ~wake_cfg_vec) == '0)
      else $error("unconfigured wake source raised a request");
   AST_EXC_SILENT: assert property (($rose(exc) && !edge_any && !pend_reg && !per_hit) |-> !pg_req)
      else $error("exception raised a pulse on occurrence");
   AST_POR_SILENT: assert property (($rose(status.supply_status[`ISU_SUP_POR]) && !edge_any && !pend_reg
                                     && !per_hit) |-> !pg_req)
      else $error("power-on flag raised a pulse");
   AST_MASK_GATE: assert property ((grp_edge & ~grp_mask_reg) == '0)
      else $error("masked group produced an edge");
   AST_MERGE: assert property (pg_low |-> !pg_start ##1 !pg_start)
      else $error("second pulse started while low");
   AST_SET_WINS: assert property (evt_set[`ISU_EVT_PULSE] |=> evt_stat_reg[`ISU_EVT_PULSE])
      else $error("pulse event lost");
   AST_IRQ_LEVEL: assert property (1'b1 |=> irq == $past(|(evt_stat_reg & evt_mask_reg)))
      else $error("irq output does not follow masked status");

   COV_WAKE_PULSE: cover property (mode_active && (|wake_edge) ##1 !irq_out_n);
   COV_PERIODIC: cover property (per_hit && exc);
   COV_MERGED: cover property (merged);
   COV_GAP_DEFER: cover property (pend_reg && !pg_low && !pg_start);

endmodule

/* verilog/isu_defs.svh */
`ifndef ISU_DEFS_SVH
`define ISU_DEFS_SVH

`define ISU_ADDR_W          8
`define ISU_DATA_W          32
`define ISU_OFS_GRP_MASK    8'h00
`define ISU_OFS_WAKE_CFG    8'h04
`define ISU_OFS_CTRL        8'h08
`define ISU_OFS_EVT_STAT    8'h0c
`define ISU_OFS_EVT_MASK    8'h10
`define ISU_OFS_FLAGS       8'h14

`define ISU_GRP_N           6
`define ISU_GRP_SUPPLY      0
`define ISU_GRP_TEMP        1
`define ISU_GRP_BUS         2
`define ISU_GRP_HS          3
`define ISU_GRP_BRIDGE      4
`define ISU_GRP_SPI_CRC     5
`define ISU_RST_GRP_MASK    6'h3f

`define ISU_WAKE_CFG_N      8
`define ISU_RST_WAKE_CFG    8'h00

`define ISU_CTRL_N          2
`define ISU_CTRL_PERIODIC   0
`define ISU_CTRL_BRAKE      1
`define ISU_RST_CTRL        2'h1

`define ISU_EVT_N           3
`define ISU_EVT_PULSE       0
`define ISU_EVT_PERIODIC    1
`define ISU_EVT_MERGED      2
`define ISU_RST_EVT_MASK    3'h0

`define ISU_FLG_EXC         8
`define ISU_FLG_PENDING     9
`define ISU_FLG_LOW         10

`define ISU_SUP_POR         0
`define ISU_SUP_UV          1
`define ISU_SUP_SC          2
`define ISU_SUP_OV          3
`define ISU_TH_THERMAL_SHUTDOWN_LEVEL2         0

`define ISU_CLK_MHZ         50
`define ISU_PULSE_WIDTH_US  100
`define ISU_PULSE_GAP_US    100
`define ISU_PERIOD_MS       5
`define ISU_PULSE_CYC       (`ISU_PULSE_WIDTH_US * `ISU_CLK_MHZ)
`define ISU_GAP_CYC         (`ISU_PULSE_GAP_US * `ISU_CLK_MHZ)
`define ISU_PERIOD_CYC      (`ISU_PERIOD_MS * 1000 * `ISU_CLK_MHZ)

`endif

/* verilog/isu_pkg.sv */
`include "isu_defs.svh"

package isu_pkg;

   typedef struct packed
   {
      logic [7:0] supply_status;
      logic [7:0] thermal_status_reg;
      logic [7:0] bus_status;
      logic [7:0] highside_fault_status_reg;
      logic [7:0] drain_source_overvoltage_reg;
      logic       spi_fail;
      logic       crc_fail;
   } isu_status_t;

   typedef struct packed
   {
      logic [3:0] lowside_brake_wake;
      logic [1:0] cyclic_wake_timer;
      logic [4:0] wake_pin;
      logic       can_wake;
   } isu_wake_t;

   typedef enum logic [5:0]
   {
      ISU_MODE_INIT     = 6'h01,
      ISU_MODE_NORMAL   = 6'h02,
      ISU_MODE_STOP     = 6'h04,
      ISU_MODE_RESTART  = 6'h08,
      ISU_MODE_FAILSAFE = 6'h10,
      ISU_MODE_SLEEP    = 6'h20
   } isu_mode_t;

   typedef enum logic [2:0]
   {
      ISU_PG_IDLE = 3'h1,
      ISU_PG_LOW  = 3'h2,
      ISU_PG_GAP  = 3'h4
   } isu_pg_state_t;

endpackage

/* verilog/isu_pulse_gen.sv */
`timescale 1ns/1ps
`include "isu_defs.svh"

module isu_pulse_gen
   import isu_pkg::*;
#(
   parameter int WIDTH_CYC = `ISU_PULSE_CYC,
   parameter int GAP_CYC   = `ISU_GAP_CYC,
   localparam int CW       = $clog2((WIDTH_CYC > GAP_CYC ? WIDTH_CYC : GAP_CYC) + 1)
)
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic active,
   input  wire logic req,
   output logic      start,
   output logic      low,
   output logic      irq_out_n
);

   isu_pg_state_t   state_reg;
   logic [CW-1:0]   cnt_reg;
   logic            last;

   assign start = active && req && (state_reg == ISU_PG_IDLE);
   assign low   = (state_reg == ISU_PG_LOW);
   assign last  = ((state_reg == ISU_PG_LOW) && (cnt_reg == CW'(WIDTH_CYC - 1))) ||
                  ((state_reg == ISU_PG_GAP) && (cnt_reg == CW'(GAP_CYC - 1)));

   // a request seen while low is never queued, so overlapping events give one pulse
   always_ff @(posedge clk)
   begin
      if (rst || !active)
         state_reg <= ISU_PG_IDLE;
      else
      begin
         unique case (state_reg)
            ISU_PG_IDLE:
               if (req)
                  state_reg <= ISU_PG_LOW;
            ISU_PG_LOW:
               if (last)
                  state_reg <= ISU_PG_GAP;
            ISU_PG_GAP:
               if (last)
                  state_reg <= ISU_PG_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst || !active || (state_reg == ISU_PG_IDLE) || last)
         cnt_reg <= '0;
      else
         cnt_reg <= cnt_reg + CW'(1);
   end

   always_ff @(posedge clk)
   begin
      if (rst || !active)
         irq_out_n <= 1'b1;
      else if (start)
         irq_out_n <= 1'b0;
      else if (low && last)
         irq_out_n <= 1'b1;
   end

   int low_run;
   int high_run;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         low_run  <= 0;
         high_run <= GAP_CYC;
      end
      else if (!irq_out_n)
      begin
         low_run  <= low_run + 1;
         high_run <= 0;
      end
      else
      begin
         low_run <= 0;
         if (high_run < GAP_CYC)
            high_run <= high_run + 1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   AST_PULSE_MAX: assert property (!irq_out_n |-> low_run < WIDTH_CYC)
      else $error("interrupt pulse longer than pulse width");
   AST_PULSE_EXACT: assert property (($rose(irq_out_n) && $past(active)) |-> low_run == WIDTH_CYC)
      else $error("interrupt pulse width wrong");
   AST_GAP_MIN: assert property ($fell(irq_out_n) |-> high_run >= GAP_CYC)
      else $error("pulse gap too short");
   AST_OFF_HIGH: assert property (!active |=> irq_out_n && !low)
      else $error("interrupt output active outside active modes");

   COV_DEFER: cover property (req && (state_reg == ISU_PG_GAP));

endmodule

/* sim/isu_host_model.sv */
`timescale 1ns/1ps

module isu_host_model
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic irq_out_n,
   output int        n_pulses,
   output int        width,
   output int        gap,
   output int        period
);
   int   low_cnt;
   int   high_cnt;
   int   since_start;
   logic pin_q;

   // the host only watches the line; it clears events by dropping the status levels in the bench
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         pin_q       <= 1'b1;
         n_pulses    <= 0;
         width       <= 0;
         gap         <= 0;
         period      <= 0;
         low_cnt     <= 0;
         high_cnt    <= 0;
         since_start <= 0;
      end
      else
      begin
         pin_q       <= irq_out_n;
         since_start <= since_start + 1;
         if (irq_out_n === 1'b0)
            low_cnt <= low_cnt + 1;
         else
            high_cnt <= high_cnt + 1;
         // a falling edge starts a pulse: record high time and start-to-start distance
         if (pin_q === 1'b1 && irq_out_n === 1'b0)
         begin
            n_pulses    <= n_pulses + 1;
            gap         <= high_cnt;
            period      <= since_start;
            since_start <= 1;
            low_cnt     <= 1;
         end
         if (pin_q === 1'b0 && irq_out_n === 1'b1)
         begin
            width    <= low_cnt;
            high_cnt <= 1;
         end
      end
   end
endmodule

/* sim/testbench.sv */
`timescale 1ns/1ps
`include "isu_defs.svh"

module testbench
   import isu_pkg::*;
;
   localparam int PW  = 8;
   localparam int GW  = 8;
   localparam int PER = 64;

   logic                   clk;
   logic                   rst;
   isu_mode_t              device_mode;
   isu_status_t            status;
   isu_wake_t              wake_status_reg;
   logic [`ISU_ADDR_W-1:0] reg_addr;
   logic [`ISU_DATA_W-1:0] reg_wr_data;
   logic                   reg_wr_en;
   logic                   reg_rd_en;
   logic [`ISU_DATA_W-1:0] reg_rd_data;
   logic                   irq_out_n;
   logic                   irq;
   int                     n_pulses;
   int                     width;
   int                     gap;
   int                     period;
   int                     failures;
   int                     n_compared;
   int                     p0;

   isu_top #(.PULSE_CYC(PW), .GAP_CYC(GW), .PERIOD_CYC(PER)) isu_top_i
   (
      .clk(clk), .rst(rst), .device_mode(device_mode), .status(status), .wake_status_reg(wake_status_reg),
      .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
      .reg_rd_data(reg_rd_data), .irq_out_n(irq_out_n), .irq(irq)
   );

   isu_host_model isu_host_model_i
   (
      .clk(clk), .rst(rst), .irq_out_n(irq_out_n), .n_pulses(n_pulses), .width(width), .gap(gap),
      .period(period)
   );

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk_eq(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         failures++;
         $display("ERROR t=%0t got %h expected %h", $time, got, exp);
      end
   endtask

   // pulses seen since p0, and the width of the last one
   task automatic chk_pulses(input int n);
      chk_eq(32'(n_pulses - p0), 32'(n));
      if (n > 0)
         chk_eq(32'(width), 32'(PW));
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr    <= a;
      reg_wr_data <= d;
      reg_wr_en   <= 1'b1;
      @(posedge clk);
      reg_wr_en <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      reg_addr  <= a;
      reg_rd_en <= 1'b1;
      @(posedge clk);
      reg_rd_en <= 1'b0;
      #1 chk_eq(reg_rd_data, exp);
   endtask

   // 0..6 group sources, 7..11 POR/UV/SC/OV/shutdown2, 12.. wake bits
   task automatic src(input int g, input logic v);
      @(posedge clk);
      case (g)
         0: status.supply_status[4] <= v;
         1: status.thermal_status_reg[3] <= v;
         2: status.bus_status[7] <= v;
         3: status.highside_fault_status_reg[0] <= v;
         4: status.drain_source_overvoltage_reg[5] <= v;
         5: status.spi_fail <= v;
         6: status.crc_fail <= v;
         7: status.supply_status[`ISU_SUP_POR] <= v;
         8: status.supply_status[`ISU_SUP_UV] <= v;
         9: status.supply_status[`ISU_SUP_SC] <= v;
         10: status.supply_status[`ISU_SUP_OV] <= v;
         11: status.thermal_status_reg[`ISU_TH_THERMAL_SHUTDOWN_LEVEL2] <= v;
         default: wake_status_reg[g-12] <= v;
      endcase
   endtask

   task automatic shot(input int g, input int n);
      p0 = n_pulses;
      src(g, 1'b1);
      cyc(30);
      chk_pulses(n);
      src(g, 1'b0);
      cyc(20);
   endtask

   initial
   begin
      repeat (20000) @(posedge clk);
      failures++;
      $display("ERROR t=%0t run did not finish in time", $time);
      report_and_stop;
   end

   initial
   begin
      rst             = 1'b1;
      device_mode     = ISU_MODE_NORMAL;
      status          = '0;
      wake_status_reg = '0;
      reg_addr        = 8'h00;
      reg_wr_data     = 32'h0;
      reg_wr_en       = 1'b0;
      reg_rd_en       = 1'b0;
      failures        = 0;
      n_compared      = 0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      rd(`ISU_OFS_GRP_MASK, 32'h3f);
      rd(`ISU_OFS_WAKE_CFG, 32'h0);
      rd(`ISU_OFS_CTRL, 32'h1);
      rd(`ISU_OFS_EVT_MASK, 32'h0);
      rd(8'h40, 32'h0);
      wr(`ISU_OFS_GRP_MASK, 32'h15);
      rd(`ISU_OFS_GRP_MASK, 32'h15);
      wr(`ISU_OFS_GRP_MASK, 32'h3f);
      wr(`ISU_OFS_CTRL, 32'h0);
      $display("test registers done");
      for (int g = 0; g < 7; g++)
         shot(g, 1);
      for (int g = 7; g < 12; g++)
         shot(g, 0);
      wr(`ISU_OFS_GRP_MASK, 32'h3b);
      shot(2, 0);
      wr(`ISU_OFS_GRP_MASK, 32'h3f);
      $display("test groups done");
      for (int i = 0; i < 9; i++)
      begin
         wr(`ISU_OFS_WAKE_CFG, 32'h0);
         shot(12 + i, 0);
         wr(`ISU_OFS_WAKE_CFG, (i < 8) ? (32'h1 << i) : 32'h0);
         wr(`ISU_OFS_CTRL, (i == 8) ? 32'h2 : 32'h0);
         shot(12 + i, 1);
      end
      wr(`ISU_OFS_WAKE_CFG, 32'h0);
      wr(`ISU_OFS_CTRL, 32'h0);
      $display("test wake done");
      wr(`ISU_OFS_EVT_STAT, 32'h7);
      p0 = n_pulses;
      src(2, 1'b1);
      cyc(3);
      src(1, 1'b1);
      cyc(30);
      chk_pulses(1);
      rd(`ISU_OFS_EVT_STAT, 32'h5);
      src(1, 1'b0);
      src(2, 1'b0);
      cyc(20);
      p0 = n_pulses;
      src(2, 1'b1);
      cyc(PW + 2);
      src(1, 1'b1);
      cyc(40);
      chk_pulses(2);
      chk_eq(32'(gap >= GW + 1), 32'h1);
      src(1, 1'b0);
      src(2, 1'b0);
      $display("test spacing done");
      wr(`ISU_OFS_EVT_STAT, 32'h7);
      wr(`ISU_OFS_EVT_MASK, 32'h1);
      src(2, 1'b1);
      cyc(5);
      chk_eq(32'(irq), 32'h1);
      rd(`ISU_OFS_EVT_STAT, 32'h1);
      wr(`ISU_OFS_EVT_STAT, 32'h1);
      cyc(2);
      chk_eq(32'(irq), 32'h0);
      wr(`ISU_OFS_EVT_MASK, 32'h0);
      src(1, 1'b1);
      cyc(30);
      chk_eq(32'(irq), 32'h0);
      src(1, 1'b0);
      src(2, 1'b0);
      $display("test interrupt done");
      @(posedge clk);
      device_mode <= ISU_MODE_SLEEP;
      cyc(2);
      p0 = n_pulses;
      src(2, 1'b1);
      cyc(30);
      chk_pulses(0);
      chk_eq(32'(irq_out_n), 32'h1);
      rd(`ISU_OFS_FLAGS, 32'h204);
      device_mode <= ISU_MODE_NORMAL;
      cyc(30);
      chk_pulses(0);
      src(2, 1'b0);
      wr(`ISU_OFS_CTRL, 32'h1);
      device_mode <= ISU_MODE_RESTART;
      src(8, 1'b1);
      cyc(100);
      chk_pulses(0);
      rd(`ISU_OFS_FLAGS, 32'h300);
      device_mode <= ISU_MODE_NORMAL;
      cyc(3 * PER + 10);
      chk_eq(32'(n_pulses - p0 >= 2), 32'h1);
      chk_eq(32'(period >= PER - 1 && period <= PER + 2), 32'h1);
      rd(`ISU_OFS_EVT_STAT, 32'h3);
      wr(`ISU_OFS_CTRL, 32'h0);
      cyc(10);
      p0 = n_pulses;
      cyc(2 * PER);
      chk_pulses(0);
      src(8, 1'b0);
      wr(`ISU_OFS_CTRL, 32'h1);
      p0 = n_pulses;
      cyc(2 * PER);
      chk_pulses(0);
      $display("test periodic done");
      report_and_stop;
   end
endmodule
